// ---- core/tmk_bank.sv ----
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// Timer channel interrupt mask and request flag bank
// ************************************************************
module tmk_bank import tmk_pkg::*; #(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output var logic [31:0] prdata,
  output var logic pready,
  output var logic pslverr,
  input wire tmk_src_s src_evt,
  output var tmk_src_s irq_req,
  output var logic irq
);

  // ************************************************************
  // Elaboration check
  // ************************************************************
  if (ADDR_W < TMK_ADDR_MIN) begin : g_bad_addr
    $error("ADDR_W is too narrow for the register map");
  end

  // ************************************************************
  // Helper functions
  // ************************************************************

  // Pick every source field out of a written byte
  function automatic tmk_src_s src_from_byte(input logic [7:0] b);
    tmk_src_s s;
    s.ch1 = b[TMK_G1L_CH1];
    s.ch1_upper = b[TMK_G1L_CH1U];
    s.ch3_upper = b[TMK_G1L_CH3U];
    s.ch2 = b[TMK_G1H_CH2];
    s.ch3 = b[TMK_G1H_CH3];
    s.ch4 = b[TMK_G2L_CH4];
    return s;
  endfunction

  // Spread per-register write strobes onto the sources they own
  function automatic tmk_src_s we_map(input logic g1l, input logic g1h,
                                      input logic g2l);
    tmk_src_s s;
    s.ch1 = g1l;
    s.ch1_upper = g1l;
    s.ch3_upper = g1l;
    s.ch2 = g1h;
    s.ch3 = g1h;
    s.ch4 = g2l;
    return s;
  endfunction

  // Group 1 low read image
  function automatic logic [7:0] byte_g1l(input tmk_src_s v,
                                          input logic fix);
    logic [7:0] b;
    b = TMK_BYTE_ZERO;
    b[TMK_G1L_CH1] = v.ch1;
    b[TMK_G1L_FIX] = fix;
    b[TMK_G1L_CH3U] = v.ch3_upper;
    b[TMK_G1L_CH1U] = v.ch1_upper;
    return b;
  endfunction

  // Group 1 high read image
  function automatic logic [7:0] byte_g1h(input tmk_src_s v);
    logic [7:0] b;
    b = TMK_BYTE_ZERO;
    b[TMK_G1H_CH2] = v.ch2;
    b[TMK_G1H_CH3] = v.ch3;
    return b;
  endfunction

  // Group 2 low read image, the ch5 bit stays zero
  function automatic logic [7:0] byte_g2l(input tmk_src_s v);
    logic [7:0] b;
    b = TMK_BYTE_ZERO;
    b[TMK_G2L_CH4] = v.ch4;
    return b;
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  tmk_src_s mask_r;
  tmk_src_s mask_nxt;
  logic [5:0] flag_q;
  logic [5:0] stat_q;
  logic [5:0] en_r;
  tmk_src_s flag_s;

  // ************************************************************
  // APB address decode
  // ************************************************************
  wire logic hit_mg1l = (paddr == ADDR_W'(TMK_OFS_MASK_G1L));
  wire logic hit_fg1l = (paddr == ADDR_W'(TMK_OFS_FLAG_G1L));
  wire logic hit_mg1h = (paddr == ADDR_W'(TMK_OFS_MASK_G1H));
  wire logic hit_fg1h = (paddr == ADDR_W'(TMK_OFS_FLAG_G1H));
  wire logic hit_mg2l = (paddr == ADDR_W'(TMK_OFS_MASK_G2L));
  wire logic hit_fg2l = (paddr == ADDR_W'(TMK_OFS_FLAG_G2L));
  wire logic hit_stat = (paddr == ADDR_W'(TMK_OFS_IRQ_STAT));
  wire logic hit_en = (paddr == ADDR_W'(TMK_OFS_IRQ_EN));
  wire logic mapped = hit_mg1l | hit_fg1l | hit_mg1h | hit_fg1h |
                      hit_mg2l | hit_fg2l | hit_stat | hit_en;

  // Access phase: first cycle is taken, second completes the transfer
  wire logic apb_req = psel & penable;
  wire logic take = apb_req & ~pready;
  wire logic commit = apb_req & pready;
  wire logic wr = commit & pwrite & pstrb[0] & mapped;

  // ************************************************************
  // Write strobes and data
  // ************************************************************
  wire tmk_src_s wd_src = src_from_byte(pwdata[7:0]);
  wire tmk_src_s mask_we = we_map(wr & hit_mg1l, wr & hit_mg1h,
                                  wr & hit_mg2l);
  wire tmk_src_s flag_we = we_map(wr & hit_fg1l, wr & hit_fg1h,
                                  wr & hit_fg2l);
  wire logic [5:0] stat_we = {TMK_SRC_N{wr & hit_stat}};
  wire logic en_we = wr & hit_en;

  assign flag_s = tmk_src_s'(flag_q);

  // ************************************************************
  // Read data selection
  // ************************************************************
  wire logic [7:0] rd_byte =
    hit_mg1l ? byte_g1l(mask_r, TMK_MASK_FIX) :
    hit_fg1l ? byte_g1l(flag_s, TMK_FLAG_FIX) :
    hit_mg1h ? byte_g1h(mask_r) :
    hit_fg1h ? byte_g1h(flag_s) :
    hit_mg2l ? byte_g2l(mask_r) :
    hit_fg2l ? byte_g2l(flag_s) :
    hit_stat ? {2'b00, stat_q} :
    hit_en ? {2'b00, en_r} :
    TMK_BYTE_ZERO;
  wire logic [31:0] rd_word = pwrite ? TMK_WORD_ZERO : {24'h00_0000, rd_byte};

  // ************************************************************
  // Mask bits
  // ************************************************************

  // Only the bits owned by the written register change
  assign mask_nxt = tmk_src_s'((mask_r & ~mask_we) | (wd_src & mask_we));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= tmk_src_s'(TMK_MASK_RST);
    end else if (pce) begin
      mask_r <= mask_nxt;
    end
  end

  // ************************************************************
  // Request flags: set by events, cleared by writing 0
  // ************************************************************
  tmk_sticky_bits #(
    .W(TMK_SRC_N),
    .RST(TMK_FLAG_RST),
    .W1C(1'b0)
  ) u_flags (
    .pclk(pclk),
    .presetn(presetn),
    .ce(pce),
    .set(src_evt),
    .we(flag_we),
    .wd(wd_src),
    .q(flag_q)
  );

  // ************************************************************
  // Interrupt status (write one to clear) and enable
  // ************************************************************
  tmk_sticky_bits #(
    .W(TMK_SRC_N),
    .RST(TMK_STAT_RST),
    .W1C(1'b1)
  ) u_status (
    .pclk(pclk),
    .presetn(presetn),
    .ce(pce),
    .set(src_evt),
    .we(stat_we),
    .wd(pwdata[5:0]),
    .q(stat_q)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r <= TMK_EN_RST;
    end else if (pce && en_we) begin
      en_r <= pwdata[5:0];
    end
  end

  // ************************************************************
  // APB answer registers
  // ************************************************************

  // One wait state: pready rises the cycle after the access is taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= TMK_WORD_ZERO;
    end else if (pce) begin
      pready <= take;
      pslverr <= take & ~mapped;
      if (take) begin
        prdata <= rd_word;
      end
    end
  end

  // ************************************************************
  // Forwarded requests and summary interrupt
  // ************************************************************

  // A request goes out only while its mask bit holds 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req <= tmk_src_s'(TMK_FLAG_RST);
      irq <= 1'b0;
    end else if (pce) begin
      irq_req <= tmk_src_s'(flag_q & ~mask_r);
      irq <= |(stat_q & en_r);
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Setup followed by the taken access cycle
  sequence s_setup_access;
    (pce && psel && !penable) ##1 (pce && psel && penable && !pready);
  endsequence

  // Read of one register taken in the access phase
  sequence s_read_taken(logic hit);
    pce && take && !pwrite && hit;
  endsequence

  chk_apb_one_wait: assert property (
    s_setup_access |=> (pready && !$past(pready))
  ) else $error("pready did not follow the access cycle");

  chk_mask_blocks_req: assert property (
    pce |=> ((irq_req & $past(mask_r)) == 6'h00) &&
            (irq_req == ($past(flag_q) & ~$past(mask_r)))
  ) else $error("masked source forwarded or open source held back");

  chk_flag_reads_back: assert property (
    s_read_taken(hit_fg1h) |=>
      prdata[1:0] == {$past(flag_s.ch3), $past(flag_s.ch2)}
  ) else $error("group 1 high flag read does not show pending state");

  chk_upper_separate: assert property (
    (pce && src_evt.ch3_upper && !src_evt.ch3 && !flag_s.ch3 &&
     !flag_we.ch3) |=> (flag_s.ch3_upper && !flag_s.ch3)
  ) else $error("upper half event disturbed the main channel flag");

  chk_mask_g1l_layout: assert property (
    s_read_taken(hit_mg1l) |=>
      prdata[7:0] == {$past(mask_r.ch1), 1'b1, 2'b00,
                      $past(mask_r.ch3_upper), 2'b00,
                      $past(mask_r.ch1_upper)}
  ) else $error("group 1 low mask layout wrong");

  chk_flag_g1l_layout: assert property (
    s_read_taken(hit_fg1l) |=>
      prdata[7:0] == {$past(flag_s.ch1), 1'b0, 2'b00,
                      $past(flag_s.ch3_upper), 2'b00,
                      $past(flag_s.ch1_upper)}
  ) else $error("group 1 low flag layout wrong");

  chk_mask_g1h_write: assert property (
    (pce && wr && hit_mg1h) |=>
      (mask_r.ch2 == $past(pwdata[0])) && (mask_r.ch3 == $past(pwdata[1]))
  ) else $error("group 1 high mask write landed on wrong bits");

  chk_flag_g1h_clear: assert property (
    (pce && wr && hit_fg1h && !pwdata[1] && !src_evt.ch3) |=>
      !flag_s.ch3
  ) else $error("writing 0 to ch3 flag did not clear it");

  chk_mask_g2l_write: assert property (
    (pce && wr && hit_mg2l) |=> mask_r.ch4 == $past(pwdata[1])
  ) else $error("group 2 low mask write landed on wrong bit");

  chk_flag_g2l_read: assert property (
    s_read_taken(hit_fg2l) |=>
      (prdata[1] == $past(flag_s.ch4)) && (prdata[2] == 1'b0)
  ) else $error("group 2 low flag read wrong");

  chk_flag_set_wins: assert property (
    (pce && src_evt.ch2) |=> flag_s.ch2
  ) else $error("event lost against mask or clear");

  chk_flag_holds: assert property (
    (pce && flag_s.ch4 && !flag_we.ch4) |=> flag_s.ch4 [*1]
  ) else $error("flag dropped without a write of 0");

  // Mask writes and reads on the remaining register layouts
  chk_mask_g1l_write: assert property (
    (pce && wr && hit_mg1l) |=>
      (mask_r.ch1 == $past(pwdata[7])) && (mask_r.ch1_upper == $past(pwdata[0]))
      && (mask_r.ch3_upper == $past(pwdata[3]))
  ) else $error("group 1 low mask write landed on wrong bits");

  chk_mask_g2l_read: assert property (
    s_read_taken(hit_mg2l) |=>
      prdata[7:0] == {5'h00, 1'b0, $past(mask_r.ch4), 1'b0}
  ) else $error("group 2 low mask read wrong");

  // Bus edge cases: unmapped address and a write without byte strobe
  chk_unmapped_err: assert property (
    (pce && take && !mapped) |=> (pready && pslverr && prdata == 32'h0000_0000)
  ) else $error("unmapped access answered without error");

  chk_no_strobe_write: assert property (
    (pce && commit && pwrite && !pstrb[0]) |=> $stable(mask_r) && $stable(en_r)
  ) else $error("write without byte strobe changed a register");

  // Status clears on a written one, the summary line follows it
  chk_status_clear: assert property (
    (pce && wr && hit_stat && pwdata[2] && !src_evt.ch2) |=> !stat_q[2]
  ) else $error("writing 1 to a status bit did not clear it");

  chk_irq_level: assert property (
    pce |=> (irq == ($past(stat_q & en_r) != 6'h00))
  ) else $error("summary interrupt does not follow enabled status");

endmodule
`default_nettype wire

// ---- core/tmk_pkg.sv ----
package tmk_pkg;

  // ************************************************************
  // Register offsets (byte addresses)
  // ************************************************************
  localparam logic [7:0] TMK_OFS_MASK_G1L = 8'h00;
  localparam logic [7:0] TMK_OFS_FLAG_G1L = 8'h04;
  localparam logic [7:0] TMK_OFS_MASK_G1H = 8'h08;
  localparam logic [7:0] TMK_OFS_FLAG_G1H = 8'h0C;
  localparam logic [7:0] TMK_OFS_MASK_G2L = 8'h10;
  localparam logic [7:0] TMK_OFS_FLAG_G2L = 8'h14;
  localparam logic [7:0] TMK_OFS_IRQ_STAT = 8'h18;
  localparam logic [7:0] TMK_OFS_IRQ_EN = 8'h1C;
  localparam int unsigned TMK_ADDR_MIN = 8;

  // ************************************************************
  // Field positions inside the 8-bit registers
  // ************************************************************
  localparam int unsigned TMK_G1L_CH1 = 7;
  localparam int unsigned TMK_G1L_FIX = 6;
  localparam int unsigned TMK_G1L_CH3U = 3;
  localparam int unsigned TMK_G1L_CH1U = 0;
  localparam int unsigned TMK_G1H_CH2 = 0;
  localparam int unsigned TMK_G1H_CH3 = 1;
  localparam int unsigned TMK_G2L_CH4 = 1;
  localparam int unsigned TMK_G2L_CH5 = 2;

  // ************************************************************
  // Fixed bits and reset values
  // ************************************************************
  localparam logic TMK_MASK_FIX = 1'b1;
  localparam logic TMK_FLAG_FIX = 1'b0;
  localparam int unsigned TMK_SRC_N = 6;
  localparam logic [5:0] TMK_MASK_RST = 6'h3F;
  localparam logic [5:0] TMK_FLAG_RST = 6'h00;
  localparam logic [5:0] TMK_STAT_RST = 6'h00;
  localparam logic [5:0] TMK_EN_RST = 6'h00;
  localparam logic [7:0] TMK_BYTE_ZERO = 8'h00;
  localparam logic [31:0] TMK_WORD_ZERO = 32'h0000_0000;

  // One bit per interrupt source, also the status/enable layout
  typedef struct packed {
    logic ch4;
    logic ch3_upper;
    logic ch3;
    logic ch2;
    logic ch1_upper;
    logic ch1;
  } tmk_src_s;

endpackage

// ---- core/tmk_sticky_bits.sv ----
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// Sticky bit bank: hardware set always wins over a clear
// ************************************************************
module tmk_sticky_bits #(
  parameter int unsigned W = 6,
  parameter logic [W-1:0] RST = '0,
  parameter bit W1C = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] we,
  input wire logic [W-1:0] wd,
  output var logic [W-1:0] q
);

  logic [W-1:0] q_nxt;
  logic [W-1:0] kept;

  // Write-one-to-clear or plain write of the enabled bits
  assign kept = W1C ? (q & ~(we & wd)) : ((q & ~we) | (wd & we));
  assign q_nxt = set | kept;

  // Bit storage, frozen while the clock enable is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= RST;
    end else if (ce) begin
      q <= q_nxt;
    end
  end

endmodule
`default_nettype wire

// ---- tb/tmk_chan_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// Timer channel model: raises one event pulse per request
// ************************************************************
module tmk_chan_model import tmk_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire tmk_src_s fire,
  input wire logic [3:0] dly,
  output var tmk_src_s src_evt
);
  tmk_src_s pend_r;
  logic [3:0] cnt_r;

  // Hold a request, wait dly cycles, then pulse its sources once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_r <= '0;
      cnt_r <= 4'h0;
      src_evt <= '0;
    end else begin
      src_evt <= '0;
      if (pend_r != '0) begin
        if (cnt_r == 4'h0) begin
          src_evt <= pend_r;
          pend_r <= '0;
        end else begin
          cnt_r <= cnt_r - 4'h1;
        end
      end else if (fire != '0) begin
        pend_r <= fire;
        cnt_r <= dly;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_top import tmk_pkg::*;;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, erv;
  logic pce;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [3:0] pstrb, dly;
  tmk_src_s src_evt, irq_req, fire;
  int err_count, n_compared;
  // Per source: flag address, mask address, bit position
  logic [7:0] fa [6] = '{8'h04, 8'h04, 8'h0C, 8'h0C, 8'h04, 8'h14};
  logic [7:0] ma [6] = '{8'h00, 8'h00, 8'h08, 8'h08, 8'h00, 8'h10};
  int bp [6] = '{7, 0, 0, 1, 3, 1};
  logic [31:0] rst_tab [8] = '{32'h0000_00C9, 32'h0000_0000,
    32'h0000_0003, 32'h0000_0000, 32'h0000_0002, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0000};

  tmk_bank uut (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_evt(src_evt), .irq_req(irq_req), .irq(irq));
  tmk_chan_model chans (.pclk(pclk), .presetn(presetn), .fire(fire),
    .dly(dly), .src_evt(src_evt));

  // ************************************************************
  // Clock, checks and bus cycles
  // ************************************************************
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // One APB transfer; holds the request until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           input logic [3:0] s);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    chk(32'(n), 32'h0000_0002);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF);
    chk(32'(erv), 32'h0000_0000);
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000, 4'hF);
    chk(rdv, e);
    chk(32'(erv), 32'h0000_0000);
  endtask

  // Ask the channel model for one event after d idle cycles
  task fire_evt(input tmk_src_s s, input logic [3:0] d);
    @(posedge pclk);
    fire <= s;
    dly <= d;
    @(posedge pclk);
    fire <= '0;
    repeat (d + 4) @(posedge pclk);
  endtask

  task wait_chk_irq(input logic [31:0] e);
    repeat (3) @(posedge pclk);
    chk(32'(irq), e);
  endtask

  // ************************************************************
  // Watchdog
  // ************************************************************
  initial begin
    #(100 * 4000);
    err_count++;
    end_sim();
  end

  // ************************************************************
  // Test sequence
  // ************************************************************
  initial begin
    presetn = 1'b0;
    pce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    fire = '0;
    dly = 4'h0;
    err_count = 0;
    n_compared = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++)
      rdc(8'(4 * i), rst_tab[i]);
    chk(32'(irq_req), 32'h0000_0000);
    $display("test reset values done");
    // Each source: set while masked, unmask, remask, clear
    for (int i = 0; i < 6; i++) begin
      fire_evt(tmk_src_s'(6'h01 << i), 4'h0);
      rdc(fa[i], 32'h0000_0001 << bp[i]);
      chk(32'(irq_req), 32'h0000_0000);
      wr(ma[i], rst_tab[ma[i] / 4] & ~(32'h0000_0001 << bp[i]));
      repeat (3) @(posedge pclk);
      chk(32'(irq_req), 32'h0000_0001 << i);
      wr(ma[i], rst_tab[ma[i] / 4]);
      wr(fa[i], 32'h0000_0000);
      rdc(fa[i], 32'h0000_0000);
      chk(32'(irq_req), 32'h0000_0000);
    end
    $display("test sources done");
    // Status, enable and level output
    rdc(TMK_OFS_IRQ_STAT, 32'h0000_003F);
    wr(TMK_OFS_IRQ_EN, 32'h0000_0004);
    wait_chk_irq(32'h0000_0001);
    wr(TMK_OFS_IRQ_EN, 32'h0000_0000);
    wait_chk_irq(32'h0000_0000);
    wr(TMK_OFS_IRQ_EN, 32'h0000_003F);
    wr(TMK_OFS_IRQ_STAT, 32'h0000_0004);
    rdc(TMK_OFS_IRQ_STAT, 32'h0000_003B);
    wait_chk_irq(32'h0000_0001);
    wr(TMK_OFS_IRQ_STAT, 32'h0000_003B);
    wait_chk_irq(32'h0000_0000);
    fire_evt(tmk_src_s'(6'h10), 4'h5);
    rdc(TMK_OFS_FLAG_G1L, 32'h0000_0008);
    chk(32'(irq), 32'h0000_0001);
    wr(TMK_OFS_IRQ_STAT, 32'h0000_0010);
    wr(TMK_OFS_FLAG_G1L, 32'h0000_0000);
    wait_chk_irq(32'h0000_0000);
    $display("test interrupt done");
    // Clock enable low: an event pulse is not taken
    @(posedge pclk);
    pce <= 1'b0;
    fire_evt(tmk_src_s'(6'h04), 4'h0);
    pce <= 1'b1;
    rdc(TMK_OFS_FLAG_G1H, 32'h0000_0000);
    rdc(TMK_OFS_IRQ_STAT, 32'h0000_0000);
    $display("test clock enable done");
    // Unmapped, strobe-less and fixed bits
    apb(1'b0, 8'h20, 32'h0000_0000, 4'hF);
    chk(32'(erv), 32'h0000_0001);
    chk(rdv, 32'h0000_0000);
    apb(1'b1, TMK_OFS_MASK_G1L, 32'h0000_0000, 4'h0);
    rdc(TMK_OFS_MASK_G1L, 32'h0000_00C9);
    wr(TMK_OFS_MASK_G1L, 32'h0000_0000);
    rdc(TMK_OFS_MASK_G1L, 32'h0000_0040);
    wr(TMK_OFS_FLAG_G1L, 32'h0000_00FF);
    rdc(TMK_OFS_FLAG_G1L, 32'h0000_0089);
    wr(TMK_OFS_MASK_G1H, 32'h0000_00FF);
    rdc(TMK_OFS_MASK_G1H, 32'h0000_0003);
    wr(TMK_OFS_FLAG_G1H, 32'h0000_00FF);
    rdc(TMK_OFS_FLAG_G1H, 32'h0000_0003);
    wr(TMK_OFS_MASK_G2L, 32'h0000_0000);
    rdc(TMK_OFS_MASK_G2L, 32'h0000_0000);
    wr(TMK_OFS_FLAG_G2L, 32'h0000_00FF);
    rdc(TMK_OFS_FLAG_G2L, 32'h0000_0002);
    chk(32'(irq_req), 32'h0000_0033);
    $display("test bus edges done");
    end_sim();
  end
endmodule
`default_nettype wire
